// >>> rtl/hpad_decoder.sv
// Host and PCI address decode and translation with AXI4-Lite registers.
//
// Notes on behaviour
// - Address bit 39 low is cached main memory, high is noncached space.
// - Byte/word mode: nibble 8,9,A,B selects PCI memory, I/O, type 0, type 1.
// - Size code 00 quadword, 01 longword, 10 word, 11 byte.
// - Byte/word decode only while control register bit 0 is set.
// - Quarter-gigabyte CSR regions decoded; the two neighbours are reserved.
// - The gigabyte at C7.C000.0000 goes to the flash ROM interface.
// - Noncached space has no mailbox; only registers, memory, PCI spaces.
// - Noncached space also yields interrupt acknowledge and special cycles.
// - PCI masters reach memory only through five windows, never config.
// - Bridge emits 32-bit PCI addresses; accepts single and dual cycles.
// - Window 4 takes dual cycles with ad 40 set; ad 33:0 passes through.
// - Window 3 is dual or single; dual needs 63:40 zero, 39:32 match.
// - Windows 0, 1 and 2 answer single-address cycles only.
// - Upper 32 address bits nonzero means dual-address, zero means single.
// - Scatter-gather moves any 8 KB PCI page to any 8 KB memory page.
// - Sparse memory regions of 512, 128, 64 MB, each relocatable.
// - Sparse I/O region A fixed at zero, region B relocatable.
// - Main memory is 8 GB, moved as aligned 64-byte blocks.
// - Sparse memory takes all noncached sizes and is never prefetched.
// - Dense memory is 4 GB, longword grain, and may be prefetched.
// - Configuration space takes sparse sizes and is never prefetched.
`timescale 1ns/100ps

module hpad_decoder #(
  parameter int SG_ENTRIES = 16
) (
  // Clock, reset and clock enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // AXI4-Lite register slave
  input wire logic [hpad_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [hpad_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Processor-side address decode
  input wire logic host_req,
  input wire logic [39:0] host_addr,
  output logic host_dec_valid,
  output hpad_pkg::hpad_host_dec_t host_dec,
  // PCI target-side address decode
  input wire logic pci_req,
  input wire logic pci_is_mem,
  input wire logic [63:0] pci_ad,
  output logic pci_dec_valid,
  output hpad_pkg::hpad_pci_dec_t pci_dec
);

  localparam int SG_AW = $clog2(SG_ENTRIES);

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [31:0] ctrl1_reg;
  logic [31:0] mem_reloc_reg;
  logic [31:0] io_reloc_reg;
  logic [7:0] dac_reg;
  logic [31:0] win_base_reg [hpad_pkg::NWIN];
  logic [31:0] win_mask_reg [hpad_pkg::NWIN];
  logic [31:0] win_tbase_reg [hpad_pkg::NWIN];
  logic [2:0] win_cfg_reg [hpad_pkg::NWIN];
  logic [20:0] sg_tab [SG_ENTRIES];

  logic aw_have_reg;
  logic w_have_reg;
  logic [hpad_pkg::AXI_AW-1:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic wr_fire;
  logic wr_ok;
  logic rd_ok;
  logic [31:0] rd_data;
  logic bw_en;

  assign bw_en = ctrl1_reg[hpad_pkg::CTRL1_BW_EN];
  assign wr_fire = aw_have_reg && w_have_reg && !s_axi_bvalid;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = data[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // ----------------------------------------------------------------
  // Write channel handshakes
  // ----------------------------------------------------------------
  // Address and data are held separately so they may arrive in any order.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_reg <= 1'b0;
      s_axi_awready <= 1'b1;
      aw_addr_reg <= '0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_reg <= 1'b1;
        s_axi_awready <= 1'b0;
        aw_addr_reg <= s_axi_awaddr;
      end else if (s_axi_bvalid && s_axi_bready) begin
        aw_have_reg <= 1'b0;
        s_axi_awready <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_reg <= 1'b0;
      s_axi_wready <= 1'b1;
      w_data_reg <= hpad_pkg::RST_ZERO;
      w_strb_reg <= 4'h0;
    end else if (ce) begin
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_reg <= 1'b1;
        s_axi_wready <= 1'b0;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end else if (s_axi_bvalid && s_axi_bready) begin
        w_have_reg <= 1'b0;
        s_axi_wready <= 1'b1;
      end
    end
  end

  always_comb begin
    unique case (aw_addr_reg[11:2])
      hpad_pkg::OFF_CTRL1[11:2], hpad_pkg::OFF_MEM_RELOC[11:2],
      hpad_pkg::OFF_IO_RELOC[11:2], hpad_pkg::OFF_DAC[11:2]: wr_ok = 1'b1;
      default: wr_ok = (aw_addr_reg[11:6] == hpad_pkg::OFF_WIN_BLK) ||
                       (aw_addr_reg[11:8] == hpad_pkg::OFF_SG_BLK &&
                        aw_addr_reg[7:2] < 6'(SG_ENTRIES));
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= hpad_pkg::RESP_OKAY;
    end else if (ce) begin
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? hpad_pkg::RESP_OKAY : hpad_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl1_reg <= hpad_pkg::RST_ZERO;
      mem_reloc_reg <= hpad_pkg::RST_ZERO;
      io_reloc_reg <= hpad_pkg::RST_ZERO;
      dac_reg <= 8'h00;
    end else if (ce && wr_fire) begin
      unique case (aw_addr_reg)
        hpad_pkg::OFF_CTRL1:
          ctrl1_reg <= merge(ctrl1_reg, w_data_reg, w_strb_reg);
        hpad_pkg::OFF_MEM_RELOC:
          mem_reloc_reg <= merge(mem_reloc_reg, w_data_reg, w_strb_reg);
        hpad_pkg::OFF_IO_RELOC:
          io_reloc_reg <= merge(io_reloc_reg, w_data_reg, w_strb_reg);
        hpad_pkg::OFF_DAC:
          if (w_strb_reg[0]) begin
            dac_reg <= w_data_reg[7:0];
          end
        default: ;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < hpad_pkg::NWIN; i++) begin
        win_base_reg[i] <= hpad_pkg::RST_ZERO;
        win_mask_reg[i] <= hpad_pkg::RST_ZERO;
        win_tbase_reg[i] <= hpad_pkg::RST_ZERO;
        win_cfg_reg[i] <= 3'h0;
      end
    end else if (ce && wr_fire &&
                 aw_addr_reg[11:6] == hpad_pkg::OFF_WIN_BLK) begin
      unique case (aw_addr_reg[3:2])
        hpad_pkg::WIN_BASE: win_base_reg[aw_addr_reg[5:4]] <=
          merge(win_base_reg[aw_addr_reg[5:4]], w_data_reg, w_strb_reg);
        hpad_pkg::WIN_MASK: win_mask_reg[aw_addr_reg[5:4]] <=
          merge(win_mask_reg[aw_addr_reg[5:4]], w_data_reg, w_strb_reg);
        hpad_pkg::WIN_TBASE: win_tbase_reg[aw_addr_reg[5:4]] <=
          merge(win_tbase_reg[aw_addr_reg[5:4]], w_data_reg, w_strb_reg);
        hpad_pkg::WIN_CFG:
          if (w_strb_reg[0]) begin
            win_cfg_reg[aw_addr_reg[5:4]] <= w_data_reg[2:0];
          end
      endcase
    end
  end

  // The table is not reset; software fills it before enabling a window.
  always_ff @(posedge aclk) begin
    if (ce && wr_fire && wr_ok &&
        aw_addr_reg[11:8] == hpad_pkg::OFF_SG_BLK) begin
      sg_tab[aw_addr_reg[SG_AW+1:2]] <= w_data_reg[20:0];
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  always_comb begin
    rd_ok = 1'b1;
    rd_data = hpad_pkg::RST_ZERO;
    unique case (s_axi_araddr[11:2])
      hpad_pkg::OFF_CTRL1[11:2]: rd_data = ctrl1_reg;
      hpad_pkg::OFF_MEM_RELOC[11:2]: rd_data = mem_reloc_reg;
      hpad_pkg::OFF_IO_RELOC[11:2]: rd_data = io_reloc_reg;
      hpad_pkg::OFF_DAC[11:2]: rd_data = {24'h000000, dac_reg};
      hpad_pkg::OFF_STATUS[11:2]:
        rd_data = {20'h00000, 2'b00, host_dec.forward, host_dec.region,
                   pci_dec.hit, pci_dec.window};
      default:
        if (s_axi_araddr[11:6] == hpad_pkg::OFF_WIN_BLK) begin
          unique case (s_axi_araddr[3:2])
            hpad_pkg::WIN_BASE: rd_data = win_base_reg[s_axi_araddr[5:4]];
            hpad_pkg::WIN_MASK: rd_data = win_mask_reg[s_axi_araddr[5:4]];
            hpad_pkg::WIN_TBASE: rd_data = win_tbase_reg[s_axi_araddr[5:4]];
            hpad_pkg::WIN_CFG:
              rd_data = {29'h00000000, win_cfg_reg[s_axi_araddr[5:4]]};
          endcase
        end else if (s_axi_araddr[11:8] == hpad_pkg::OFF_SG_BLK &&
                     s_axi_araddr[7:2] < 6'(SG_ENTRIES)) begin
          rd_data = {11'h000, sg_tab[s_axi_araddr[SG_AW+1:2]]};
        end else begin
          rd_ok = 1'b0;
        end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= hpad_pkg::RST_ZERO;
      s_axi_rresp <= hpad_pkg::RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_data;
        s_axi_rresp <= rd_ok ? hpad_pkg::RESP_OKAY : hpad_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Processor address decode
  // ----------------------------------------------------------------
  // Mailbox space does not exist: noncached space holds only registers,
  // diagnostic memory and PCI spaces, and anything else is reserved.
  hpad_pkg::hpad_host_dec_t hd;
  logic [3:0] nib;

  assign nib = host_addr[35:32];

  always_comb begin
    hd = '0;
    hd.region = hpad_pkg::HR_RESERVED;
    hd.sparse_len = host_addr[6:3];
    if (!host_addr[39]) begin
      if (host_addr[38:33] == 6'h00) begin
        hd.region = hpad_pkg::HR_MAIN;
        hd.block64 = 1'b1;
        hd.mem_addr = {host_addr[32:hpad_pkg::BLOCK_BITS],
                       6'h00};
      end else if (host_addr[38:32] == 7'h0e) begin
        hd.region = hpad_pkg::HR_DUMMY;
      end
    end else if (bw_en && nib[3:2] == 2'b10) begin
      hd.size = host_addr[38:37];
      hd.pci_addr = host_addr[31:0];
      unique case (nib[1:0])
        2'b00: hd.region = hpad_pkg::HR_BW_MEM;
        2'b01: hd.region = hpad_pkg::HR_BW_IO;
        2'b10: begin
          hd.region = hpad_pkg::HR_BW_CFG0;
          hd.pci_addr[1:0] = 2'b00;
        end
        2'b11: begin
          hd.region = hpad_pkg::HR_BW_CFG1;
          hd.pci_addr[1:0] = 2'b01;
        end
      endcase
    end else if (!nib[3]) begin
      unique case (nib[2:0])
        3'h0, 3'h1, 3'h2, 3'h3: begin
          hd.region = hpad_pkg::HR_SPM0;
          hd.pci_addr = {mem_reloc_reg[hpad_pkg::MR0_LSB +: 3],
                         host_addr[33:7], 2'b00};
        end
        3'h4: begin
          hd.region = hpad_pkg::HR_SPM1;
          hd.pci_addr = {mem_reloc_reg[hpad_pkg::MR1_LSB +: 5],
                         host_addr[31:7], 2'b00};
        end
        3'h5:
          if (!host_addr[31]) begin
            hd.region = hpad_pkg::HR_SPM2;
            hd.pci_addr = {mem_reloc_reg[hpad_pkg::MR2_LSB +: 6],
                           host_addr[30:7], 2'b00};
          end else if (!host_addr[30]) begin
            hd.region = hpad_pkg::HR_SPIOA;
            hd.pci_addr = {7'h00, host_addr[29:7], 2'b00};
          end else begin
            hd.region = hpad_pkg::HR_SPIOB;
            hd.pci_addr = {io_reloc_reg[hpad_pkg::IOB_LSB +: 7],
                           host_addr[29:7], 2'b00};
          end
        3'h6: begin
          hd.region = hpad_pkg::HR_DENSE;
          hd.prefetch_ok = 1'b1;
          hd.pci_addr = {host_addr[31:2], 2'b00};
        end
        3'h7: begin
          hd.pci_addr = {4'h0, host_addr[27:0]};
          unique case (host_addr[31:28])
            4'h0, 4'h1: begin
              hd.region = hpad_pkg::HR_CFG_SPARSE;
              hd.pci_addr = {9'h000, host_addr[27:7], 2'b00};
            end
            4'h2, 4'h3: hd.region = hpad_pkg::HR_SPECIAL;
            4'h4: hd.region = hpad_pkg::HR_CSR_MAIN;
            4'h5: hd.region = hpad_pkg::HR_CSR_MEM;
            4'h6: hd.region = hpad_pkg::HR_CSR_XLATE;
            4'h7, 4'hb: hd.region = hpad_pkg::HR_RESERVED;
            4'h8: hd.region = hpad_pkg::HR_CSR_MISC;
            4'h9: hd.region = hpad_pkg::HR_CSR_PM;
            4'ha: hd.region = hpad_pkg::HR_CSR_INT;
            4'hc, 4'hd, 4'he, 4'hf: begin
              hd.region = hpad_pkg::HR_FLASH;
              hd.pci_addr = {2'b00, host_addr[29:0]};
            end
          endcase
        end
      endcase
    end
    hd.forward = (hd.region != hpad_pkg::HR_RESERVED);
    if (!hd.forward) begin
      hd.pci_addr = 32'h0000_0000;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      host_dec_valid <= 1'b0;
      host_dec <= '{region: hpad_pkg::HR_RESERVED, default: '0};
    end else if (ce) begin
      host_dec_valid <= host_req;
      if (host_req) begin
        host_dec <= hd;
      end
    end
  end

  // ----------------------------------------------------------------
  // PCI target window decode
  // ----------------------------------------------------------------
  logic dual;
  logic [hpad_pkg::NWIN-1:0] win_hit;
  logic [33:0] win_addr [hpad_pkg::NWIN];

  assign dual = |pci_ad[63:32];

  for (genvar i = 0; i < hpad_pkg::NWIN; i++) begin : g_win
    logic [31:0] msk;
    logic [31:0] off;
    logic [33:0] base;
    logic cyc_ok;
    logic [SG_AW-1:0] idx;
    assign msk = {win_mask_reg[i][31:hpad_pkg::WIN_GRAIN], 20'hfffff};
    assign off = pci_ad[31:0] & msk;
    assign base = {win_tbase_reg[i], 2'b00};
    if (i == hpad_pkg::DAC_WIN) begin : g_dac
      assign cyc_ok = win_cfg_reg[i][hpad_pkg::CFG_DAC] ?
        (dual && pci_ad[63:40] == 24'h000000 &&
         pci_ad[39:32] == dac_reg) : !dual;
    end else begin : g_sac
      assign cyc_ok = !dual;
    end
    assign win_hit[i] = pci_is_mem && win_cfg_reg[i][hpad_pkg::CFG_EN] &&
      cyc_ok && ((pci_ad[31:20] & ~msk[31:20]) ==
                 (win_base_reg[i][31:20] & ~msk[31:20]));
    assign idx = SG_AW'(win_tbase_reg[i][SG_AW-1:0] +
                        off[hpad_pkg::PAGE_BITS +: SG_AW]);
    assign win_addr[i] = win_cfg_reg[i][hpad_pkg::CFG_SG] ?
      {sg_tab[idx], off[12:0]} :
      ((base & ~{2'b00, msk}) | {2'b00, off});
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pci_dec_valid <= 1'b0;
      pci_dec <= '0;
    end else if (ce) begin
      pci_dec_valid <= pci_req;
      if (pci_req) begin
        pci_dec <= '0;
        if (pci_is_mem && dual && pci_ad[40]) begin
          pci_dec.hit <= 1'b1;
          pci_dec.monster <= 1'b1;
          pci_dec.window <= 3'h4;
          pci_dec.mem_addr <= pci_ad[33:0];
        end else begin
          for (int w = hpad_pkg::NWIN - 1; w >= 0; w--) begin
            if (win_hit[w]) begin
              pci_dec.hit <= 1'b1;
              pci_dec.sg <= win_cfg_reg[w][hpad_pkg::CFG_SG];
              pci_dec.window <= 3'(w);
              pci_dec.mem_addr <= win_addr[w];
            end
          end
        end
      end
    end
  end

endmodule // hpad_decoder

// >>> inc/hpad_pkg.sv
// Package of constants and carrier types for the host/PCI address decoder.
package hpad_pkg;

  // ----------------------------------------------------------------
  // Register offsets on the register bus
  // ----------------------------------------------------------------
  localparam int AXI_AW = 12;
  localparam logic [11:0] OFF_CTRL1 = 12'h000;
  localparam logic [11:0] OFF_MEM_RELOC = 12'h004;
  localparam logic [11:0] OFF_IO_RELOC = 12'h008;
  localparam logic [11:0] OFF_DAC = 12'h00c;
  localparam logic [11:0] OFF_STATUS = 12'h010;
  localparam logic [5:0] OFF_WIN_BLK = 6'h01;
  localparam logic [3:0] OFF_SG_BLK = 4'h1;
  localparam logic [1:0] WIN_BASE = 2'h0;
  localparam logic [1:0] WIN_MASK = 2'h1;
  localparam logic [1:0] WIN_TBASE = 2'h2;
  localparam logic [1:0] WIN_CFG = 2'h3;
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL1_BW_EN = 0;
  localparam int CFG_EN = 0;
  localparam int CFG_SG = 1;
  localparam int CFG_DAC = 2;
  localparam int MR0_LSB = 29;
  localparam int MR1_LSB = 11;
  localparam int MR2_LSB = 2;
  localparam int IOB_LSB = 25;
  localparam int NWIN = 4;
  localparam int DAC_WIN = 3;
  localparam int WIN_GRAIN = 20;
  localparam int PAGE_BITS = 13;
  localparam int BLOCK_BITS = 6;

  // ----------------------------------------------------------------
  // Codes
  // ----------------------------------------------------------------
  localparam logic [1:0] QUADWORD_SIZE = 2'b00;
  localparam logic [1:0] LONGWORD_SIZE = 2'b01;
  localparam logic [1:0] WORD_SIZE = 2'b10;
  localparam logic [1:0] BYTE_SIZE = 2'b11;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [4:0] {
    HR_MAIN, HR_DUMMY, HR_SPM0, HR_SPM1, HR_SPM2, HR_SPIOA, HR_SPIOB,
    HR_DENSE, HR_CFG_SPARSE, HR_SPECIAL, HR_CSR_MAIN, HR_CSR_MEM,
    HR_CSR_XLATE, HR_CSR_MISC, HR_CSR_PM, HR_CSR_INT, HR_BW_MEM,
    HR_BW_IO, HR_BW_CFG0, HR_BW_CFG1, HR_FLASH, HR_RESERVED
  } hpad_region_t;

  typedef struct packed {
    hpad_region_t region;
    logic forward;
    logic prefetch_ok;
    logic block64;
    logic [1:0] size;
    logic [3:0] sparse_len;
    logic [31:0] pci_addr;
    logic [32:0] mem_addr;
  } hpad_host_dec_t;

  typedef struct packed {
    logic hit;
    logic monster;
    logic sg;
    logic [2:0] window;
    logic [33:0] mem_addr;
  } hpad_pci_dec_t;

endpackage

// >>> verification/hpad_decoder_sva.sv
// Port checker of the host/PCI address decoder.
`timescale 1ns/100ps

module hpad_decoder_sva (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // Host side
  input wire logic host_req,
  input wire logic [39:0] host_addr,
  input wire logic host_dec_valid,
  input hpad_pkg::hpad_host_dec_t host_dec,
  // PCI side
  input wire logic pci_req,
  input wire logic pci_is_mem,
  input wire logic [63:0] pci_ad,
  input wire logic pci_dec_valid,
  input hpad_pkg::hpad_pci_dec_t pci_dec
);
  // ------
  // Checks
  // ------
  logic [33:0] ad_reg;
  always_ff @(posedge aclk) ad_reg <= pci_ad[33:0];
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_cached_main: assert property (host_req && ce && host_addr[39:33] == 7'h0 |=>
    host_dec_valid && host_dec.region == hpad_pkg::HR_MAIN &&
    host_dec.block64 && host_dec.mem_addr[5:0] == 6'h0) else $error("main");
  a_flash_route: assert property (host_req && ce && host_addr[39] &&
    host_addr[35:30] == 6'h1f |=> host_dec.region == hpad_pkg::HR_FLASH)
    else $error("flash route");
  a_reserved_drop: assert property (host_dec_valid &&
    host_dec.region == hpad_pkg::HR_RESERVED |-> !host_dec.forward &&
    host_dec.pci_addr == 32'h0) else $error("reserved forwarded");
  a_sparse_no_prefetch: assert property (host_dec_valid &&
    host_dec.region inside {hpad_pkg::HR_SPM0, hpad_pkg::HR_SPM1,
    hpad_pkg::HR_SPM2, hpad_pkg::HR_CFG_SPARSE} |-> !host_dec.prefetch_ok)
    else $error("sparse prefetch");
  a_monster_map: assert property (pci_req && ce && pci_is_mem &&
    pci_ad[40] |=> pci_dec.hit && pci_dec.monster &&
    pci_dec.mem_addr == ad_reg) else $error("monster map");
  a_io_no_hit: assert property (pci_req && ce && !pci_is_mem |=>
    pci_dec_valid && !pci_dec.hit) else $error("non-memory hit");
  a_single_no_monster: assert property (pci_req && ce &&
    pci_ad[63:32] == 32'h0 |=> pci_dec_valid && !pci_dec.monster)
    else $error("single cycle monster");
  a_dual_low_windows: assert property (pci_req && ce &&
    pci_ad[63:32] != 32'h0 |=> !(pci_dec.hit && pci_dec.window < 3'd3))
    else $error("dual hit window 0-2");
  a_dual_upper_zero: assert property (pci_req && ce &&
    pci_ad[63:41] != 23'h0 |=> !(pci_dec.hit && pci_dec.window == 3'd3))
    else $error("window 3 upper bits");
  c_flash: cover property (host_dec_valid &&
    host_dec.region == hpad_pkg::HR_FLASH);
  c_monster: cover property (pci_dec_valid && pci_dec.monster);
  c_window: cover property (pci_dec_valid && pci_dec.hit && !pci_dec.monster);
endmodule // hpad_decoder_sva

bind hpad_decoder hpad_decoder_sva i_sva (.aclk, .aresetn, .ce, .host_req,
  .host_addr, .host_dec_valid, .host_dec, .pci_req, .pci_is_mem, .pci_ad,
  .pci_dec_valid, .pci_dec);

// >>> verification/hpad_host_cpu.sv
// Processor bus model that issues host addresses to the decoder.
`timescale 1ns/100ps

module hpad_host_cpu (
  // Clock
  input wire logic aclk,
  // Command from the bench
  input wire logic cmd_go,
  input wire logic [39:0] cmd_addr,
  input wire logic [1:0] cmd_size,
  // Processor address bus
  output logic host_req,
  output logic [39:0] host_addr
);
  // ------
  // Bus
  // ------
  initial host_req = 1'b0;
  initial host_addr = 40'h0;
  // An idle bus inverts the address it shows on every cycle, never a held value.
  always @(posedge aclk) begin
    host_req <= cmd_go;
    host_addr <= cmd_go ? cmd_addr : ~host_addr;
    if (cmd_go && cmd_addr[39]) begin
      host_addr[38:37] <= (cmd_addr[35:30] == 6'h1f) ?
        hpad_pkg::BYTE_SIZE : cmd_size;
    end
  end
endmodule // hpad_host_cpu

// >>> verification/hpad_decoder_tb.sv
// Self-checking bench of the host/PCI address decoder.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin \
  fails++; $display("BAD %s exp %h got %h", nm, e, g); end end

module hpad_decoder_tb;
  logic aclk, aresetn, ce, go, pci_req, pci_is_mem, host_req, hdv, pdv;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [31:0] rs = 32'h26b2e9c1;
  logic [1:0] bresp, rresp, csize;
  logic [39:0] caddr, host_addr;
  logic [63:0] pci_ad;
  logic [7:0] he;
  logic [33:0] re;
  hpad_pkg::hpad_host_dec_t hd;
  hpad_pkg::hpad_pci_dec_t pd, pe;
  logic [7:0] hq[$];
  logic [39:0] pq[$];
  logic [33:0] rq[$];
  int fails, cmp_count;
  logic [19:0] tbl[20] = '{20'h000_00, 20'h0e0_01, 20'h800_02, 20'h840_03,
    20'h850_04, 20'h858_05, 20'h85c_06, 20'h860_07, 20'h870_08, 20'h872_09,
    20'h874_0a, 20'h875_0b, 20'h876_0c, 20'h877_15, 20'h878_0d, 20'h879_0e,
    20'h87a_0f, 20'h87b_15, 20'hc7c_14, 20'h880_15};

  hpad_decoder #(.SG_ENTRIES(16)) i_dut (.aclk, .aresetn, .ce,
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .host_req, .host_addr,
    .host_dec_valid(hdv), .host_dec(hd), .pci_req, .pci_is_mem, .pci_ad,
    .pci_dec_valid(pdv), .pci_dec(pd));
  hpad_host_cpu i_cpu (.aclk, .cmd_go(go), .cmd_addr(caddr),
    .cmd_size(csize), .host_req, .host_addr);

  // ------
  // Tasks
  // ------
  task automatic give_verdict();
    $display("cmp_count %0d fails %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  function automatic void step();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
  endfunction
  task automatic wt(inout int n);
    @(posedge aclk);
    n++;
    if (n > 200) begin
      fails++;
      $display("BAD wait exp answer got none");
      give_verdict();
    end
  endtask
  task automatic axw(input logic [11:0] a, input logic [31:0] d,
                     input logic [1:0] r = hpad_pkg::RESP_OKAY);
    int n;
    n = 0;
    rq.push_back({r, 32'h0});
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      wt(n);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic axr(input logic [11:0] a, input logic [33:0] e);
    int n;
    n = 0;
    rq.push_back(e);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      wt(n);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic hreq(input logic [39:0] a, input logic [1:0] s,
                      input logic [7:0] e);
    go <= 1'b1;
    caddr <= a;
    csize <= s;
    hq.push_back(e);
    @(posedge aclk);
  endtask
  task automatic preq(input logic m, input logic [63:0] a,
                      input logic [39:0] e);
    pci_req <= 1'b1;
    pci_is_mem <= m;
    pci_ad <= a;
    pq.push_back(e);
    @(posedge aclk);
  endtask
  task automatic drain(input string nm);
    int n;
    n = 0;
    go <= 1'b0;
    pci_req <= 1'b0;
    while (hq.size() + pq.size() > 0) wt(n);
    $display("test %s done", nm);
  endtask

  // ------
  // Checking and stimulus
  // ------
  always @(posedge aclk) begin
    if (hdv === 1'b1) begin
      he = hq.pop_front();
      `CHK("region", he[4:0], hd.region)
      if (he[7]) `CHK("size", he[6:5], hd.size)
    end
    if (pdv === 1'b1) begin
      pe = pq.pop_front();
      `CHK("hit", pe.hit, pd.hit)
      `CHK("map", pe, pd)
    end
    if (bvalid === 1'b1 && bready) begin
      re = rq.pop_front();
      `CHK("bresp", re[33:32], bresp)
    end
    if (rvalid === 1'b1 && rready) begin
      re = rq.pop_front();
      `CHK("rdata", re, {rresp, rdata})
    end
  end
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  initial begin
    {aresetn, go, pci_req, pci_is_mem, awvalid, wvalid, bready} = 7'h0;
    {arvalid, rready, awaddr, araddr, wdata, csize, caddr, pci_ad} = 0;
    ce = 1'b1;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axw(12'hffc, 32'h1, hpad_pkg::RESP_SLVERR);
    axr(12'hffc, {hpad_pkg::RESP_SLVERR, 32'h0});
    axr(hpad_pkg::OFF_CTRL1, 34'h0);
    for (int i = 0; i < 20; i++) begin
      step();
      hreq({tbl[i][19:8], rs[27:0]}, 2'b00, tbl[i][7:0]);
    end
    drain("map off");
    axw(hpad_pkg::OFF_CTRL1, 32'h1);
    axr(hpad_pkg::OFF_CTRL1, 34'h1);
    for (int i = 0; i < 16; i++) begin
      step();
      hreq({1'b1, i[3:2], 3'b010, i[1:0], rs}, i[3:2],
        {1'b1, i[3:2], 5'd16 + i[1:0]});
    end
    drain("byte word");
    axw(12'h040, 32'h4000_0000);
    axw(12'h044, 32'h0ff0_0000);
    axw(12'h048, 32'h0800_0000);
    axw(12'h04c, 32'h1);
    axw(12'h070, 32'h6000_0000);
    axw(12'h074, 32'h0ff0_0000);
    axw(12'h078, 32'h0c00_0000);
    axw(12'h07c, 32'h5);
    axw(hpad_pkg::OFF_DAC, 32'h5);
    step();
    preq(1'b1, 64'h4120_0000, {6'b100_000, 34'h2120_0000});
    preq(1'b1, 64'h1_4120_0000, 40'h0);
    preq(1'b0, 64'h4120_0000, 40'h0);
    preq(1'b1, 64'h8000_0000, 40'h0);
    preq(1'b1, 64'h5_6010_0000, {6'b100_011, 34'h3010_0000});
    preq(1'b1, 64'h6_6010_0000, 40'h0);
    preq(1'b1, 64'h1_0005_6010_0000, 40'h0);
    preq(1'b1, 64'h6010_0000, 40'h0);
    preq(1'b1, {24'h1, 6'h0, rs[1:0], rs}, {6'b110_100, rs[1:0], rs});
    preq(1'b0, {24'h1, 6'h0, rs[1:0], rs}, 40'h0);
    drain("pci");
    give_verdict();
  end
endmodule // hpad_decoder_tb
